// >>> hdl/ors_defs.vh
`ifndef ORS_DEFS_VH
`define ORS_DEFS_VH

// code widths
`define ORS_VREF_W 11
`define ORS_IREF_W 8
`define ORS_VHI_W 8
`define ORS_VLO_W 3
`define ORS_SPD_W 2
`define ORS_CNT_W 16
`define ORS_TIME_W 32
`define ORS_RETRY_W 8

// voltage code ceiling
`define ORS_VREF_MAX 11'h780

// timing
`define ORS_CLK_NS 8
`define ORS_CLK_MHZ 125
`define ORS_SERVO_MASTER_NS 1000
`define ORS_SERVO_MASTER_CYC (`ORS_SERVO_MASTER_NS / `ORS_CLK_NS)
`define ORS_HICCUP_US 1000
`define ORS_HICCUP_CYC (`ORS_HICCUP_US * `ORS_CLK_MHZ)

// servo divide ratios per speed code
`define ORS_DIV_R0 1
`define ORS_DIV_R1 2
`define ORS_DIV_R2 4
`define ORS_DIV_R3 8

// sync-fault state codes
`define ORS_ST_RUN 2'h0
`define ORS_ST_WAIT 2'h1
`define ORS_ST_RETRY 2'h2
`define ORS_ST_LATCH 2'h3

`endif

// >>> hdl/ors_servo_div.v
`timescale 1ns/1ps
`include "ors_defs.vh"

module ors_servo_div #(
    parameter MASTER_CYC = `ORS_SERVO_MASTER_CYC,
    parameter RATIO0 = `ORS_DIV_R0,
    parameter RATIO1 = `ORS_DIV_R1,
    parameter RATIO2 = `ORS_DIV_R2,
    parameter RATIO3 = `ORS_DIV_R3
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [`ORS_SPD_W-1:0] speed,
    output reg tick_ff
);
    localparam integer MASTER_LAST_I = MASTER_CYC - 1;
    localparam [`ORS_CNT_W-1:0] MASTER_LAST = MASTER_LAST_I[`ORS_CNT_W-1:0];

    reg [`ORS_CNT_W-1:0] master_cnt_ff;
    reg [`ORS_CNT_W-1:0] ratio_cnt_ff;
    wire master_tick;
    wire [`ORS_CNT_W-1:0] ratio_last;

    // last count of the ratio stage for a speed code
    function [`ORS_CNT_W-1:0] last_of;
        input [`ORS_SPD_W-1:0] spd;
        reg [`ORS_TIME_W-1:0] ratio_m1;
        begin
            case (spd)
                2'h0: ratio_m1 = RATIO0 - 1;
                2'h1: ratio_m1 = RATIO1 - 1;
                2'h2: ratio_m1 = RATIO2 - 1;
                default: ratio_m1 = RATIO3 - 1;
            endcase
            last_of = ratio_m1[`ORS_CNT_W-1:0];
        end
    endfunction

    assign master_tick = (master_cnt_ff == MASTER_LAST);
    assign ratio_last = last_of(speed);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            master_cnt_ff <= {`ORS_CNT_W{1'b0}};
            ratio_cnt_ff <= {`ORS_CNT_W{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (master_tick) begin
                master_cnt_ff <= {`ORS_CNT_W{1'b0}};
                // speed change mid-count restarts cleanly via >=
                if (ratio_cnt_ff >= ratio_last) begin // [R12]
                    ratio_cnt_ff <= {`ORS_CNT_W{1'b0}};
                    tick_ff <= 1'b1;
                end else begin
                    ratio_cnt_ff <= ratio_cnt_ff + 1'b1;
                end
            end else begin
                master_cnt_ff <= master_cnt_ff + 1'b1;
            end
        end
    end
endmodule

// >>> hdl/ors_servo_cnt.v
`timescale 1ns/1ps
`include "ors_defs.vh"

module ors_servo_cnt #(
    parameter W = `ORS_VREF_W
) (
    input wire sys_clk,
    input wire rst_n,
    input wire hold_zero,
    input wire tick,
    input wire [W-1:0] target,
    output reg [W-1:0] value_ff
);
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_ff <= {W{1'b0}};
        end else if (hold_zero) begin
            value_ff <= {W{1'b0}};
        end else if (tick) begin
            // comparator: step one count while unequal
            if (value_ff < target) begin // [R9] [R10]
                value_ff <= value_ff + 1'b1;
            end else if (value_ff > target) begin // [R9] [R10]
                value_ff <= value_ff - 1'b1;
            end
        end
    end
endmodule

// >>> hdl/ors_top.v
// Contract
// [R1] fault select high: latch regulator off
// [R2] fault select low: hiccup wait, then retry
// [R3] voltage code is high byte plus three
// [R4] codes above maximum clamp to maximum
// [R5] host writes both halves before load
// [R6] load moves whole 11-bit target at once
// [R7] target writes alone change nothing applied
// [R8] current code is 8-bit current target
// [R9] comparator and up/down counter per path
// [R10] step toward target each servo tick
// [R11] both channels ramp independently
// [R12] speed field selects servo divide ratio
// [R13] four speed codes, four parameter ratios
// [R14] internal enable is pin OR register
// [R15] voltage counter zero while enable low
// [R16] regulator off while enable low
// [R17] regulator on while enable high
// [R18] discharge on when selected and disabled
// [R19] output high impedance when not selected
// [R20] open pin reads high, enables at ready
// [R21] second hysteresis source while pin high
// [R22] host holds pin low long enough
// [R23] load command is one-shot, self-clearing; here pending follows the load_cmd level
`timescale 1ns/1ps
`include "ors_defs.vh"

module ors_top #(
    parameter HICCUP_CYC = `ORS_HICCUP_CYC,
    parameter MASTER_CYC = `ORS_SERVO_MASTER_CYC,
    parameter RATIO0 = `ORS_DIV_R0,
    parameter RATIO1 = `ORS_DIV_R1,
    parameter RATIO2 = `ORS_DIV_R2,
    parameter RATIO3 = `ORS_DIV_R3
) (
    input wire sys_clk,
    input wire rstn,
    input wire en_pin,
    input wire bias_ready,
    input wire reg_enable,
    input wire load_cmd,
    input wire [`ORS_VHI_W-1:0] vtarget_hi,
    input wire [`ORS_VLO_W-1:0] vtarget_lo,
    input wire [`ORS_IREF_W-1:0] itarget,
    input wire [`ORS_SPD_W-1:0] servo_speed,
    input wire discharge_sel,
    input wire sync_fault_sel,
    input wire sync_wdt_event,
    input wire sync_stable,
    output wire [`ORS_VREF_W-1:0] voltage_reference_output,
    output wire [`ORS_IREF_W-1:0] current_reference_converter,
    output reg [`ORS_VREF_W-1:0] vtarget_applied_ff,
    output reg internal_enable_ff,
    output reg regulator_on_ff,
    output reg discharge_on_ff,
    output reg output_hiz_ff,
    output reg hyst_src2_on_ff,
    output reg load_pending_ff,
    output reg vtarget_clamped_ff,
    output reg latched_off_ff,
    output reg hiccup_wait_ff,
    output reg [7:0] hiccup_retries_ff,
    output reg v_ramping_ff,
    output reg i_ramping_ff,
    output reg v_at_target_ff
);
    localparam [1:0] ST_RUN = `ORS_ST_RUN;
    localparam [1:0] ST_WAIT = `ORS_ST_WAIT;
    localparam [1:0] ST_RETRY = `ORS_ST_RETRY;
    localparam [1:0] ST_LATCH = `ORS_ST_LATCH;
    localparam [`ORS_TIME_W-1:0] HICCUP_LAST = HICCUP_CYC - 1;
    localparam [`ORS_VREF_W-1:0] VREF_MAX = `ORS_VREF_MAX;
    localparam [`ORS_RETRY_W-1:0] RETRY_MAX = {`ORS_RETRY_W{1'b1}};
    localparam [`ORS_RETRY_W-1:0] RETRY_STEP = {{(`ORS_RETRY_W-1){1'b0}}, 1'b1};

    // reset release
    reg rst_meta_ff;
    reg rst_sync_ff;
    wire rst_n;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // pin synchronisers
    reg en_meta_ff;
    reg en_sync_ff;
    reg wdt_meta_ff;
    reg wdt_sync_ff;
    reg wdt_prev_ff;
    reg stable_meta_ff;
    reg stable_sync_ff;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_meta_ff <= 1'b0;
            en_sync_ff <= 1'b0;
        end else begin
            // short low pulses may be missed here [R22]
            en_meta_ff <= en_pin;
            en_sync_ff <= en_meta_ff;
        end
    end

    // watchdog event edge detect on the synced copy
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_meta_ff <= 1'b0;
            wdt_sync_ff <= 1'b0;
            wdt_prev_ff <= 1'b0;
        end else begin
            wdt_meta_ff <= sync_wdt_event;
            wdt_sync_ff <= wdt_meta_ff;
            wdt_prev_ff <= wdt_sync_ff;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_meta_ff <= 1'b0;
            stable_sync_ff <= 1'b0;
        end else begin
            stable_meta_ff <= sync_stable;
            stable_sync_ff <= stable_meta_ff;
        end
    end

    wire wdt_hit;
    wire nxt_internal_enable;

    assign wdt_hit = wdt_sync_ff & ~wdt_prev_ff;
    // an open pin reads high through its pull-up [R20]
    assign nxt_internal_enable = en_sync_ff | reg_enable; // [R14]

    // clamp a voltage code to the ceiling
    function [`ORS_VREF_W-1:0] clamp_v;
        input [`ORS_VREF_W-1:0] code;
        begin
            if (code > VREF_MAX) begin
                clamp_v = VREF_MAX;
            end else begin
                clamp_v = code;
            end
        end
    endfunction

    // state entered on a watchdog event
    function [1:0] fault_entry;
        input latch_sel;
        begin
            if (latch_sel) begin
                fault_entry = ST_LATCH; // [R1]
            end else begin
                fault_entry = ST_WAIT; // [R2]
            end
        end
    endfunction

    // target assembly and load
    wire [`ORS_VREF_W-1:0] vtarget_raw;
    wire nxt_load_pending;

    assign vtarget_raw = {vtarget_hi, vtarget_lo}; // [R3]
    // pending copies load_cmd one cycle later, so a held command loads again every cycle [R23]
    assign nxt_load_pending = load_cmd;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pending_ff <= 1'b0;
            vtarget_applied_ff <= {`ORS_VREF_W{1'b0}};
            vtarget_clamped_ff <= 1'b0;
        end else begin
            load_pending_ff <= nxt_load_pending; // [R23]
            // halves settle before the command [R5]
            if (load_pending_ff) begin // [R7]
                vtarget_applied_ff <= clamp_v(vtarget_raw); // [R6] [R4]
                vtarget_clamped_ff <= (vtarget_raw > VREF_MAX); // [R4]
            end
        end
    end

    // sync-input fault handling
    reg [1:0] fault_st_ff;
    reg [1:0] nxt_fault_st;
    reg [`ORS_TIME_W-1:0] wait_cnt_ff;
    reg [`ORS_TIME_W-1:0] nxt_wait_cnt;
    wire wait_done;

    assign wait_done = (wait_cnt_ff >= HICCUP_LAST);

    always @* begin
        nxt_fault_st = fault_st_ff;
        nxt_wait_cnt = wait_cnt_ff;
        case (fault_st_ff)
            ST_RUN: begin
                if (internal_enable_ff && wdt_hit) begin
                    nxt_wait_cnt = {`ORS_TIME_W{1'b0}};
                    nxt_fault_st = fault_entry(sync_fault_sel); // [R1] [R2]
                end
            end
            ST_WAIT: begin
                if (wait_done) begin
                    nxt_fault_st = ST_RETRY; // [R2]
                end else begin
                    nxt_wait_cnt = wait_cnt_ff + 1'b1;
                end
            end
            ST_RETRY: begin
                if (wdt_hit) begin
                    nxt_wait_cnt = {`ORS_TIME_W{1'b0}};
                    nxt_fault_st = fault_entry(sync_fault_sel); // [R1] [R2]
                end else if (stable_sync_ff) begin
                    nxt_fault_st = ST_RUN; // [R2]
                end
            end
            ST_LATCH: begin
                nxt_fault_st = ST_LATCH; // [R1]
            end
            default: begin
                nxt_fault_st = ST_RUN;
            end
        endcase
        // dropping the enable clears any fault state
        if (!internal_enable_ff && fault_st_ff != ST_LATCH) begin
            nxt_fault_st = ST_RUN;
            nxt_wait_cnt = {`ORS_TIME_W{1'b0}};
        end else if (!internal_enable_ff) begin
            nxt_fault_st = ST_RUN;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_st_ff <= ST_RUN;
            wait_cnt_ff <= {`ORS_TIME_W{1'b0}};
        end else begin
            fault_st_ff <= nxt_fault_st;
            wait_cnt_ff <= nxt_wait_cnt;
        end
    end

    // saturating count of hiccup retries
    wire retry_start;

    assign retry_start = (fault_st_ff == ST_WAIT) && (nxt_fault_st == ST_RETRY);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hiccup_retries_ff <= {`ORS_RETRY_W{1'b0}};
        end else if (!internal_enable_ff) begin
            hiccup_retries_ff <= {`ORS_RETRY_W{1'b0}};
        end else if (retry_start && hiccup_retries_ff != RETRY_MAX) begin // [R2]
            hiccup_retries_ff <= hiccup_retries_ff + RETRY_STEP;
        end
    end

    // servo
    wire servo_tick;
    wire [`ORS_IREF_W-1:0] itarget_applied;

    assign itarget_applied = itarget; // [R8]

    ors_servo_div #(
        .MASTER_CYC(MASTER_CYC),
        .RATIO0(RATIO0),
        .RATIO1(RATIO1),
        .RATIO2(RATIO2),
        .RATIO3(RATIO3)
    ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .speed(servo_speed), // [R12] [R13]
        .tick_ff(servo_tick)
    );

    // shared tick, separate counters [R11]
    ors_servo_cnt #(
        .W(`ORS_VREF_W)
    ) u_vcnt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hold_zero(~internal_enable_ff), // [R15]
        .tick(servo_tick), // [R10]
        .target(vtarget_applied_ff), // [R9]
        .value_ff(voltage_reference_output)
    );

    ors_servo_cnt #(
        .W(`ORS_IREF_W)
    ) u_icnt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hold_zero(1'b0),
        .tick(servo_tick), // [R10] [R11]
        .target(itarget_applied), // [R9] [R8]
        .value_ff(current_reference_converter)
    );

    // enable control and status
    wire fault_off;
    wire nxt_regulator_on;
    wire v_equal;
    wire i_equal;

    assign fault_off = (fault_st_ff == ST_WAIT) || (fault_st_ff == ST_LATCH);
    assign nxt_regulator_on = internal_enable_ff & bias_ready & ~fault_off; // [R16] [R17]
    assign v_equal = (voltage_reference_output == vtarget_applied_ff);
    assign i_equal = (current_reference_converter == itarget_applied);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_enable_ff <= 1'b0;
            regulator_on_ff <= 1'b0;
            discharge_on_ff <= 1'b0;
            output_hiz_ff <= 1'b1;
            hyst_src2_on_ff <= 1'b0;
        end else begin
            internal_enable_ff <= nxt_internal_enable; // [R14]
            regulator_on_ff <= nxt_regulator_on; // [R16] [R17] [R20]
            discharge_on_ff <= ~nxt_regulator_on & discharge_sel; // [R18]
            output_hiz_ff <= ~nxt_regulator_on & ~discharge_sel; // [R19]
            hyst_src2_on_ff <= en_sync_ff; // [R21]
        end
    end

    // fault and ramp status flags
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_off_ff <= 1'b0;
            hiccup_wait_ff <= 1'b0;
            v_ramping_ff <= 1'b0;
            i_ramping_ff <= 1'b0;
            v_at_target_ff <= 1'b0;
        end else begin
            latched_off_ff <= (nxt_fault_st == ST_LATCH); // [R1]
            hiccup_wait_ff <= (nxt_fault_st == ST_WAIT); // [R2]
            v_ramping_ff <= internal_enable_ff & ~v_equal;
            i_ramping_ff <= ~i_equal;
            v_at_target_ff <= internal_enable_ff & v_equal;
        end
    end
endmodule

// >>> testbench/ors_monitor.sv
`timescale 1ns/1ps
module ors_monitor (
    input wire sys_clk,
    input wire rstn,
    input wire en_pin,
    input wire reg_enable,
    input wire load_cmd,
    input wire [7:0] vtarget_hi,
    input wire [2:0] vtarget_lo,
    input wire discharge_sel,
    input wire [10:0] voltage_reference_output,
    input wire [10:0] vtarget_applied_ff,
    input wire internal_enable_ff,
    input wire regulator_on_ff,
    input wire discharge_on_ff,
    input wire output_hiz_ff,
    input wire load_pending_ff,
    input wire latched_off_ff,
    input wire hiccup_wait_ff
);
    wire [10:0] code = {vtarget_hi, vtarget_lo};
    wire [10:0] vro = voltage_reference_output;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_load_pulse: assert property (load_cmd |=> load_pending_ff)
        else $error("load pulse missing");
    chk_load_value: assert property (load_cmd |=> ##1 vtarget_applied_ff ==
        ($past(code, 2) > 11'h780 ? 11'h780 : $past(code, 2)))
        else $error("applied code wrong");
    chk_applied_hold: assert property (!load_pending_ff |=> $stable(vtarget_applied_ff))
        else $error("applied changed without load");
    chk_ien_or: assert property ((reg_enable or en_pin [*4]) |=> internal_enable_ff)
        else $error("internal enable low");
    chk_reg_off: assert property (!internal_enable_ff |=> !regulator_on_ff)
        else $error("regulator on while disabled");
    chk_dis_hiz: assert property ({discharge_on_ff, output_hiz_ff} ==
        {!regulator_on_ff && $past(discharge_sel), !regulator_on_ff && !$past(discharge_sel)})
        else $error("discharge or hiz wrong");
    chk_v_zero: assert property (!internal_enable_ff [*3] |-> vro == 11'h000)
        else $error("voltage counter not zero");
    chk_v_step: assert property (internal_enable_ff && $past(internal_enable_ff)
        && vro != $past(vro) |-> vro == $past(vro) + 11'h001 || vro == $past(vro) - 11'h001)
        else $error("voltage counter jumped");
    chk_latch_off: assert property (latched_off_ff && $past(latched_off_ff)
        |-> !regulator_on_ff)
        else $error("regulator on while latched");
    chk_latch_keep: assert property (latched_off_ff && internal_enable_ff |=> latched_off_ff)
        else $error("latch released");
    chk_hiccup_off: assert property (hiccup_wait_ff [*2] |-> !regulator_on_ff)
        else $error("regulator on in hiccup wait");
endmodule
bind ors_top ors_monitor ors_monitor_inst (.sys_clk, .rstn, .en_pin, .reg_enable, .load_cmd,
    .vtarget_hi, .vtarget_lo, .discharge_sel, .voltage_reference_output, .vtarget_applied_ff,
    .internal_enable_ff, .regulator_on_ff, .discharge_on_ff, .output_hiz_ff, .load_pending_ff,
    .latched_off_ff, .hiccup_wait_ff);

// >>> testbench/ors_host.sv
`timescale 1ns/1ps
module ors_host (
    input wire sys_clk,
    output logic load_cmd,
    output logic [7:0] vtarget_hi,
    output logic [2:0] vtarget_lo
);
    initial begin
        load_cmd = 1'b0;
        vtarget_hi = 8'h00;
        vtarget_lo = 3'h0;
    end
    task automatic load(input logic [10:0] code, input logic go);
        @(posedge sys_clk) #1 vtarget_hi = code[10:3];
        @(posedge sys_clk) #1 vtarget_lo = code[2:0];
        if (go) begin
            @(posedge sys_clk) #1 load_cmd = 1'b1;
            @(posedge sys_clk) #1 load_cmd = 1'b0;
        end
    endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic sys_clk, rstn, en_pin, bias_ready, reg_enable, discharge_sel;
    logic sync_fault_sel, sync_wdt_event, sync_stable;
    logic [7:0] itarget;
    logic [1:0] servo_speed;
    wire load_cmd;
    wire [7:0] vtarget_hi, current_reference_converter, hiccup_retries_ff;
    wire [2:0] vtarget_lo;
    wire [10:0] voltage_reference_output, vtarget_applied_ff;
    wire internal_enable_ff, regulator_on_ff, discharge_on_ff, output_hiz_ff, hyst_src2_on_ff;
    wire load_pending_ff, vtarget_clamped_ff, latched_off_ff, hiccup_wait_ff;
    wire v_ramping_ff, i_ramping_ff, v_at_target_ff;
    int fail_count = 0;
    int n_checks = 0;
    ors_host ors_host_inst (.sys_clk, .load_cmd, .vtarget_hi, .vtarget_lo);
    ors_top #(.HICCUP_CYC(20), .MASTER_CYC(2)) ors_top_inst (.sys_clk, .rstn, .en_pin,
        .bias_ready, .reg_enable, .load_cmd, .vtarget_hi, .vtarget_lo, .itarget, .servo_speed,
        .discharge_sel, .sync_fault_sel, .sync_wdt_event, .sync_stable,
        .voltage_reference_output, .current_reference_converter, .vtarget_applied_ff,
        .internal_enable_ff, .regulator_on_ff, .discharge_on_ff, .output_hiz_ff,
        .hyst_src2_on_ff, .load_pending_ff, .vtarget_clamped_ff, .latched_off_ff,
        .hiccup_wait_ff, .hiccup_retries_ff, .v_ramping_ff, .i_ramping_ff, .v_at_target_ff);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_ref(input logic [10:0] v, input logic [7:0] i);
        int k = 0;
        while ((voltage_reference_output !== v || current_reference_converter !== i)
            && k < 4000) begin
            cyc(1);
            k++;
        end
    endtask
    // cycles until the current counter moves
    task automatic gap(output int n);
        logic [7:0] m = current_reference_converter;
        n = 0;
        while (current_reference_converter === m && n < 200) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_load;
        ors_host_inst.load(11'h123, 1'b1);
        cyc(2);
        chk("applied", 11'h123, vtarget_applied_ff);
        ors_host_inst.load(11'h5aa, 1'b0);
        cyc(4);
        chk("applied held", 11'h123, vtarget_applied_ff);
        ors_host_inst.load(11'h7ff, 1'b1);
        cyc(2);
        chk("clamp", 11'h780, vtarget_applied_ff);
        chk("clamp flag", 11'h001, {10'h0, vtarget_clamped_ff});
        $display("test load done");
    endtask
    task automatic t_servo;
        ors_host_inst.load(11'h010, 1'b1);
        reg_enable = 1'b1;
        cyc(10);
        itarget = 8'h09;
        cyc(1);
        chk("i ramping", 11'h001, {10'h0, i_ramping_ff});
        wait_ref(11'h010, 8'h09);
        cyc(20);
        chk("vref", 11'h010, voltage_reference_output);
        chk("iref", 11'h009, {3'h0, current_reference_converter});
        chk("v at target", 11'h001, {10'h0, v_at_target_ff});
        chk("v settled", 11'h000, {10'h0, v_ramping_ff});
        chk("i settled", 11'h000, {10'h0, i_ramping_ff});
        ors_host_inst.load(11'h00b, 1'b1);
        cyc(3);
        chk("v ramping", 11'h001, {10'h0, v_ramping_ff});
        chk("v not at target", 11'h000, {10'h0, v_at_target_ff});
        wait_ref(11'h00b, 8'h09);
        chk("vref down", 11'h00b, voltage_reference_output);
        $display("test servo done");
    endtask
    task automatic t_speed;
        int n;
        for (int s = 0; s < 4; s++) begin
            servo_speed = s[1:0];
            itarget = current_reference_converter + 8'h03;
            repeat (3) gap(n);
            chk("servo gap", 11'(2 << s), 11'(n));
        end
        $display("test speed done");
    endtask
    task automatic t_enable;
        reg_enable = 1'b0;
        en_pin = 1'b1;
        cyc(6);
        chk("pin enable", 11'h001, {10'h0, regulator_on_ff});
        chk("hyst on", 11'h001, {10'h0, hyst_src2_on_ff});
        discharge_sel = 1'b1;
        en_pin = 1'b0;
        cyc(6);
        chk("regulator off", 11'h000, {10'h0, regulator_on_ff});
        chk("discharge", 11'h001, {10'h0, discharge_on_ff});
        chk("hyst off", 11'h000, {10'h0, hyst_src2_on_ff});
        chk("vref reset", 11'h000, voltage_reference_output);
        discharge_sel = 1'b0;
        cyc(2);
        chk("hiz", 11'h001, {10'h0, output_hiz_ff});
        reg_enable = 1'b1;
        cyc(3);
        chk("reg enable", 11'h001, {10'h0, regulator_on_ff});
        bias_ready = 1'b0;
        cyc(2);
        chk("bias wait", 11'h000, {10'h0, regulator_on_ff});
        bias_ready = 1'b1;
        cyc(2);
        chk("bias ready", 11'h001, {10'h0, regulator_on_ff});
        $display("test enable done");
    endtask
    task automatic wdt_event;
        sync_wdt_event = 1'b1;
        cyc(4);
        sync_wdt_event = 1'b0;
        cyc(4);
    endtask
    task automatic t_fault;
        sync_fault_sel = 1'b1;
        wdt_event();
        cyc(40);
        chk("latched", 11'h001, {10'h0, latched_off_ff});
        chk("latched off", 11'h000, {10'h0, regulator_on_ff});
        reg_enable = 1'b0;
        cyc(6);
        reg_enable = 1'b1;
        sync_fault_sel = 1'b0;
        cyc(4);
        wdt_event();
        chk("hiccup wait", 11'h001, {10'h0, hiccup_wait_ff});
        chk("hiccup off", 11'h000, {10'h0, regulator_on_ff});
        cyc(25);
        chk("retry on", 11'h001, {10'h0, regulator_on_ff});
        wdt_event();
        chk("second wait", 11'h001, {10'h0, hiccup_wait_ff});
        cyc(25);
        sync_stable = 1'b1;
        cyc(4);
        chk("run on", 11'h001, {10'h0, regulator_on_ff});
        chk("retries", 11'h002, {3'h0, hiccup_retries_ff});
        $display("test fault done");
    endtask
    initial begin
        rstn = 1'b0;
        en_pin = 1'b0;
        bias_ready = 1'b1;
        reg_enable = 1'b0;
        discharge_sel = 1'b0;
        sync_fault_sel = 1'b0;
        sync_wdt_event = 1'b0;
        sync_stable = 1'b0;
        itarget = 8'h00;
        servo_speed = 2'h0;
        repeat (8) @(posedge sys_clk);
        #1 rstn = 1'b1;
        cyc(4);
        t_load();
        t_servo();
        t_speed();
        t_enable();
        t_fault();
        complete_run();
    end
    initial begin
        #200000;
        fail_count++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end
endmodule
